/* File: design/ptx_pkg.sv */
// ptx_pkg: constants, field layouts and types of the pwm timer extensions.
// assumes one 100 MHz clock and an avalon-mm master for the registers.
package ptx_pkg;
	localparam int          CNT_W     = 24;
	localparam int          NCH       = 4;
	localparam int          CTRL_W    = 14;
	localparam int          EVC_W     = 11;
	// ***************************************************************
	// register offsets (byte addresses)
	// ***************************************************************
	localparam logic [5:0]  OFF_CTRL  = 6'h00;
	localparam logic [5:0]  OFF_CMD   = 6'h04;
	localparam logic [5:0]  OFF_EVC   = 6'h08;
	localparam logic [5:0]  OFF_STAT  = 6'h0c;
	localparam logic [5:0]  OFF_COUNT = 6'h10;
	localparam logic [5:0]  OFF_PER   = 6'h14;
	localparam logic [5:0]  OFF_PERB  = 6'h18;
	localparam logic [5:0]  OFF_DRV   = 6'h1c;
	localparam logic [1:0]  OFF_CV_HI = 2'h2;
	localparam logic [1:0]  OFF_CB_HI = 2'h3;
	// command and status bit positions
	localparam int          CMD_SR_SET = 0;
	localparam int          CMD_SR_CLR = 1;
	localparam int          CMD_RETRIG = 2;
	localparam int          CMD_IDX_LO = 3;
	localparam int          ST_STOP   = 0;
	localparam int          ST_SRUN   = 1;
	localparam int          ST_IDX    = 2;
	localparam int          ST_ERR    = 3;
	localparam int          ST_MF_LO  = 4;
	localparam int          ST_CBV_LO = 8;
	localparam logic [23:0] RST_PER   = 24'hffffff;
	localparam logic [23:0] HALF_MAX  = 24'h800000;
	localparam logic [5:0]  MASK16    = 6'h0f;
	localparam logic [5:0]  MASK32    = 6'h1f;
	localparam logic [5:0]  MASK64    = 6'h3f;
	typedef enum logic [1:0] {WV_SINGLE, WV_DUAL, WV_DUAL_BOTH, WV_RSVD} ptx_wave_t;
	typedef enum logic [1:0] {RES_NONE, RES_DITH16, RES_DITH32, RES_DITH64} ptx_res_t;
	typedef enum logic [1:0] {RAMP_SINGLE, RAMP_INTER, RAMP_INTER_ALT, RAMP_RSVD} ptx_ramp_t;
	typedef enum logic [1:0] {EVA_OFF, EVA_RSVD, EVA_PPW, EVA_PWP} ptx_evact_t;
	typedef enum logic [1:0] {IDX_NONE, IDX_SET_A, IDX_SET_B, IDX_TOGGLE} ptx_idx_t;
	typedef enum {CS_RUN, CS_HALTED} ptx_state_t;
	typedef struct packed {
		logic       min_capture;
		logic [1:0] fault_latch;
		logic [1:0] fault_en;
		logic       circ_per_en;
		logic       circ_en;
		ptx_ramp_t  ramp;
		ptx_res_t   res;
		ptx_wave_t  wave;
		logic       enable;
	} ptx_ctrl_t;
	typedef struct packed {
		logic [3:0] cap_en;
		logic [3:0] ev_in_en;
		logic       invert;
		ptx_evact_t act1;
	} ptx_evc_t;
endpackage

/* File: design/ptx_timer.sv */
// ptx_timer: counter, capture, single run, dither, ramps and fault clamp.
// assumes event and fault inputs already synchronous to clk_i.
//
// Decided for this implementation: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
module ptx_timer import ptx_pkg::*; (
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic [5:0]  avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [3:0]  avs_byteenable_i,
	input  wire logic [31:0] avs_writedata_i,
	output logic      [31:0] avs_readdata_o,
	output logic             avs_waitrequest_o,
	input  wire logic [3:0]  ev_capture_i,
	input  wire logic        ev_in1_i,
	input  wire logic        ev_retrigger_i,
	input  wire logic        ev_start_i,
	input  wire logic        fault_a_i,
	input  wire logic        fault_b_i,
	output logic      [3:0]  waveform_output_o
);
	// ***************************************************************
	// state
	// ***************************************************************
	ptx_state_t        st_reg, st_next;
	ptx_ctrl_t         ctrl_reg, ctrl_next;
	ptx_evc_t          evc_reg, evc_next;
	logic [7:0]        drv_reg, drv_next;
	logic [CNT_W-1:0]  count_reg, count_next;
	logic              dir_reg, dir_next;
	logic [CNT_W-1:0]  per_reg, per_next;
	logic [CNT_W-1:0]  perb_reg, perb_next;
	logic [CNT_W-1:0]  cv_reg [NCH];
	logic [CNT_W-1:0]  cv_next [NCH];
	logic [CNT_W-1:0]  cb_reg [NCH];
	logic [CNT_W-1:0]  cb_next [NCH];
	logic [NCH-1:0]    cbv_reg, cbv_next;
	logic [NCH-1:0]    full_reg, full_next;
	logic [NCH-1:0]    mf_reg, mf_next;
	logic              err_reg, err_next;
	logic              srun_reg, srun_next;
	logic              idx_reg, idx_next;
	logic [5:0]        dcyc_reg, dcyc_next;
	logic [1:0]        lat_reg, lat_next;
	logic              in1_reg;
	logic [NCH-1:0]    wave_reg;
	logic              wait_reg, wait_next;
	logic [31:0]       rdata_reg, rdata_next;
	// ***************************************************************
	// helpers
	// ***************************************************************
	logic [31:0]       bw, rmux;
	logic [7:0]        cmd;
	logic              wr_fire, rd_fire, wr_cv, wr_cb;
	logic [2:0]        sh;
	logic [5:0]        mask;
	logic [CNT_W-1:0]  top, cap_val;
	logic              single, run, resume, upd, ovf, circ_ok, ramp_on;
	logic              rise, fall, rst_edge, oth_edge, ppw_on, ppw_restart;
	logic [NCH-1:0]    std_ev, ppw_hit, raw_w, wave_next;
	logic [NCH-1:0]    flt_act;

	// extra clock for this pwm cycle of the frame
	function automatic logic extra_cycle(input logic [5:0] msk,
		input logic [5:0] dcy, input logic [5:0] cyc);
		logic [11:0] prod;
		prod = cyc * dcy;
		return ({1'b0, prod[5:0] & msk} + {1'b0, dcy}) > {1'b0, msk};
	endfunction

	// dither frame length and mask from the resolution field
	always_comb begin
		case (ctrl_reg.res)
			RES_DITH16: begin sh = 3'h4; mask = MASK16; end
			RES_DITH32: begin sh = 3'h5; mask = MASK32; end
			RES_DITH64: begin sh = 3'h6; mask = MASK64; end
			default:    begin sh = 3'h0; mask = 6'h00; end
		endcase
	end

	// period stretch of one clock on selected frame cycles
	assign top = (per_reg >> sh) + {23'h0, extra_cycle(mask, per_reg[5:0] & mask, dcyc_reg)};
	assign single  = (ctrl_reg.wave == WV_SINGLE);
	assign run     = ctrl_reg.enable && (st_reg == CS_RUN);
	assign cmd     = avs_writedata_i[7:0] & bw[7:0];
	assign resume  = ctrl_reg.enable && ((wr_fire && avs_address_i == OFF_CMD
		&& cmd[CMD_RETRIG]) || ev_retrigger_i || ev_start_i);
	// update points: wrap in single slope, bottom or both in dual slope
	assign ovf = run && !resume && (single ? (count_reg >= top)
		: (dir_reg && count_reg == '0));
	assign upd = ovf || (run && !resume && ctrl_reg.wave == WV_DUAL_BOTH
		&& !dir_reg && count_reg >= top);
	assign ramp_on = single && (ctrl_reg.ramp != RAMP_SINGLE);
	assign circ_ok = ramp_on || ctrl_reg.wave == WV_DUAL_BOTH;
	// direction in msb marks the ramp when top leaves it free
	assign cap_val = (!single && top < HALF_MAX)
		? {dir_reg, count_reg[CNT_W-2:0]} : count_reg;

	// two-edge capture edges; the restart edge follows invert
	assign rise     = ev_in1_i && !in1_reg;
	assign fall     = !ev_in1_i && in1_reg;
	assign rst_edge = evc_reg.invert ? fall : rise;
	assign oth_edge = evc_reg.invert ? rise : fall;
	assign ppw_on   = (evc_reg.act1 == EVA_PPW) || (evc_reg.act1 == EVA_PWP);
	assign ppw_restart = run && ppw_on && rst_edge;
	// faults only steer channels 0 and 1; inputs are taken as-is
	assign flt_act = {2'b00, ctrl_reg.fault_en & ({fault_b_i, fault_a_i} | lat_reg)};

	// ***************************************************************
	// per channel capture qualification and waveform
	// ***************************************************************
	for (genvar g = 0; g < NCH; g++) begin : g_ch
		logic [CNT_W-1:0] cmp;
		logic             src, dis, min_ok, ppw_ch;
		// minimum capture on channels 0 and 1 keeps only new lows, and zero while up is lost
		assign min_ok = !(ctrl_reg.min_capture && g < 2) ||
			(cap_val < cv_reg[g] && (dir_reg || count_reg != '0));
		assign ppw_ch = (g == 0) ? (evc_reg.act1 == EVA_PPW) : (evc_reg.act1 == EVA_PWP);
		assign std_ev[g] = ev_capture_i[g] && evc_reg.ev_in_en[g] && evc_reg.cap_en[g]
			&& !(ppw_on && g < 2) && min_ok;
		assign ppw_hit[g] = ppw_on && g < 2 && evc_reg.ev_in_en[g] && evc_reg.cap_en[g]
			&& (ppw_ch ? rst_edge : oth_edge);
		assign cmp = (cv_reg[g] >> sh)
			+ {23'h0, extra_cycle(mask, cv_reg[g][5:0] & mask, dcyc_reg)};
		assign raw_w[g] = single ? (count_reg < cmp) : (count_reg >= cmp);
		// alternate ramp with circular period reuses channel 0 compare on output 1
		assign src = (g == 1 && ctrl_reg.ramp == RAMP_INTER_ALT && ramp_on
			&& ctrl_reg.circ_per_en) ? raw_w[0] : raw_w[g];
		assign dis = ramp_on && ((g % 2 == 1) ? !idx_reg : idx_reg);
		always_comb begin
			if (st_reg == CS_HALTED && drv_reg[g])
				wave_next[g] = drv_reg[g+4];
			else if (!ctrl_reg.enable || dis || flt_act[g])
				wave_next[g] = 1'b0;
			else
				wave_next[g] = src;
		end
	end

	// ***************************************************************
	// timer next state
	// ***************************************************************
	always_comb begin
		st_next = st_reg;
		ctrl_next = ctrl_reg;
		evc_next = evc_reg;
		drv_next = drv_reg;
		count_next = count_reg;
		dir_next = dir_reg;
		per_next = per_reg;
		perb_next = perb_reg;
		cv_next = cv_reg;
		cb_next = cb_reg;
		cbv_next = cbv_reg;
		full_next = full_reg;
		mf_next = mf_reg;
		err_next = err_reg;
		srun_next = srun_reg;
		idx_next = idx_reg;
		dcyc_next = dcyc_reg;
		lat_next = lat_reg;
		// software writes go first so hardware sets win
		if (wr_fire) begin
			if (avs_address_i == OFF_CTRL)
				ctrl_next = ptx_ctrl_t'((ctrl_reg & ~bw[CTRL_W-1:0])
					| (avs_writedata_i[CTRL_W-1:0] & bw[CTRL_W-1:0]));
			else if (avs_address_i == OFF_EVC)
				evc_next = ptx_evc_t'((evc_reg & ~bw[EVC_W-1:0])
					| (avs_writedata_i[EVC_W-1:0] & bw[EVC_W-1:0]));
			else if (avs_address_i == OFF_DRV)
				drv_next = (drv_reg & ~bw[7:0]) | cmd;
			else if (avs_address_i == OFF_PER)
				per_next = (per_reg & ~bw[CNT_W-1:0]) | (avs_writedata_i[CNT_W-1:0] & bw[CNT_W-1:0]);
			else if (avs_address_i == OFF_PERB)
				perb_next = (perb_reg & ~bw[CNT_W-1:0]) | (avs_writedata_i[CNT_W-1:0] & bw[CNT_W-1:0]);
			else if (avs_address_i == OFF_STAT) begin
				err_next = err_reg & ~(avs_writedata_i[ST_ERR] & bw[ST_ERR]);
				mf_next = mf_reg & ~(avs_writedata_i[ST_MF_LO+:NCH] & bw[ST_MF_LO+:NCH]);
			end else if (avs_address_i == OFF_CMD) begin
				if (cmd[CMD_SR_CLR])
					srun_next = 1'b0;
				if (cmd[CMD_SR_SET])
					srun_next = 1'b1;
				case (ptx_idx_t'(cmd[CMD_IDX_LO+:2]))
					IDX_SET_A:  idx_next = 1'b0;
					IDX_SET_B:  idx_next = 1'b1;
					IDX_TOGGLE: idx_next = !idx_reg;
					default:    idx_next = idx_reg;
				endcase
			end
		end
		for (int i = 0; i < NCH; i++) begin
			if (wr_cv && avs_address_i[3:2] == i[1:0])
				cv_next[i] = (cv_reg[i] & ~bw[CNT_W-1:0]) | (avs_writedata_i[CNT_W-1:0] & bw[CNT_W-1:0]);
			if (wr_cb && avs_address_i[3:2] == i[1:0])
				cb_next[i] = (cb_reg[i] & ~bw[CNT_W-1:0]) | (avs_writedata_i[CNT_W-1:0] & bw[CNT_W-1:0]);
		end
		// counter: resume, restart, wrap or turn around
		if (resume) begin
			st_next = CS_RUN;
			count_next = '0;
			dir_next = 1'b0;
		end else if (ppw_restart) begin
			count_next = '0;
		end else if (run) begin
			if (ovf && srun_reg)
				st_next = CS_HALTED;
			else if (single)
				count_next = (count_reg >= top) ? '0 : count_reg + 24'h1;
			else if (!dir_reg) begin
				if (count_reg >= top) begin
					dir_next = 1'b1;
					count_next = (count_reg == '0) ? '0 : count_reg - 24'h1;
				end else
					count_next = count_reg + 24'h1;
			end else if (count_reg == '0) begin
				dir_next = 1'b0;
				count_next = 24'h1;
			end else
				count_next = count_reg - 24'h1;
		end
		// update: frame cycle, ramp index, circular swaps, fault latch end
		if (upd) begin
			dcyc_next = dcyc_reg + 6'h1;
			if (ramp_on)
				idx_next = !idx_reg;
			lat_next = 2'b00;
			if (circ_ok && (ctrl_reg.circ_en || ctrl_reg.circ_per_en)) begin
				per_next = perb_reg;
				perb_next = per_reg;
			end
		end
		for (int f = 0; f < 2; f++)
			if (ctrl_reg.fault_en[f] && ctrl_reg.fault_latch[f]
				&& (f == 0 ? fault_a_i : fault_b_i))
				lat_next[f] = 1'b1;
		// capture channels
		for (int i = 0; i < NCH; i++) begin
			if (rd_fire && avs_address_i[5:4] == OFF_CV_HI && avs_address_i[3:2] == i[1:0])
				full_next[i] = 1'b0;
			if (upd && circ_ok && ctrl_reg.circ_en && !evc_reg.cap_en[i]) begin
				cv_next[i] = cb_reg[i];
				cb_next[i] = cv_reg[i];
			end
			// buffer drains into an empty or read channel value
			if (cbv_reg[i] && !full_next[i]) begin
				cv_next[i] = cb_reg[i];
				full_next[i] = 1'b1;
				cbv_next[i] = 1'b0;
				mf_next[i] = 1'b1;
			end
			if (std_ev[i]) begin
				if (cbv_reg[i])
					err_next = 1'b1;
				else begin
					cb_next[i] = cap_val;
					cbv_next[i] = 1'b1;
				end
			end
			if (ppw_hit[i]) begin
				if (mf_reg[i])
					err_next = 1'b1;
				else begin
					cv_next[i] = cap_val;
					full_next[i] = 1'b1;
					mf_next[i] = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			st_reg <= CS_RUN;
			ctrl_reg <= '0;
			evc_reg <= '0;
			drv_reg <= '0;
			count_reg <= '0;
			dir_reg <= 1'b0;
			per_reg <= RST_PER;
			perb_reg <= RST_PER;
			cv_reg <= '{default: '0};
			cb_reg <= '{default: '0};
			cbv_reg <= '0;
			full_reg <= '0;
			mf_reg <= '0;
			err_reg <= 1'b0;
			srun_reg <= 1'b0;
			idx_reg <= 1'b0;
			dcyc_reg <= '0;
			lat_reg <= '0;
			in1_reg <= 1'b0;
			wave_reg <= '0;
		end else begin
			st_reg <= st_next;
			ctrl_reg <= ctrl_next;
			evc_reg <= evc_next;
			drv_reg <= drv_next;
			count_reg <= count_next;
			dir_reg <= dir_next;
			per_reg <= per_next;
			perb_reg <= perb_next;
			cv_reg <= cv_next;
			cb_reg <= cb_next;
			cbv_reg <= cbv_next;
			full_reg <= full_next;
			mf_reg <= mf_next;
			err_reg <= err_next;
			srun_reg <= srun_next;
			idx_reg <= idx_next;
			dcyc_reg <= dcyc_next;
			lat_reg <= lat_next;
			in1_reg <= ev_in1_i;
			wave_reg <= wave_next;
		end
	end

	// ***************************************************************
	// avalon-mm slave: one wait cycle, then a single accept edge
	// ***************************************************************
	assign bw = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
		{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
	assign wr_fire = avs_write_i && !wait_reg;
	assign rd_fire = avs_read_i && !wait_reg;
	assign wr_cv   = wr_fire && avs_address_i[5:4] == OFF_CV_HI;
	assign wr_cb   = wr_fire && avs_address_i[5:4] == OFF_CB_HI;

	// read mux; the capture buffer never reads back
	always_comb begin
		rmux = 32'h0;
		if (avs_address_i == OFF_CTRL)
			rmux = {18'h0, ctrl_reg};
		else if (avs_address_i == OFF_EVC)
			rmux = {21'h0, evc_reg};
		else if (avs_address_i == OFF_STAT)
			rmux = {20'h0, cbv_reg, mf_reg, err_reg, idx_reg, srun_reg, st_reg == CS_HALTED};
		else if (avs_address_i == OFF_COUNT)
			rmux = {8'h0, count_reg << sh};
		else if (avs_address_i == OFF_PER)
			rmux = {8'h0, per_reg};
		else if (avs_address_i == OFF_PERB)
			rmux = {8'h0, perb_reg};
		else if (avs_address_i == OFF_DRV)
			rmux = {24'h0, drv_reg};
		else if (avs_address_i[5:4] == OFF_CV_HI)
			rmux = {8'h0, cv_reg[avs_address_i[3:2]]};
	end

	always_comb begin
		wait_next = !((avs_read_i || avs_write_i) && wait_reg);
		rdata_next = (avs_read_i && wait_reg) ? rmux : rdata_reg;
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			wait_reg <= 1'b1;
			rdata_reg <= '0;
		end else begin
			wait_reg <= wait_next;
			rdata_reg <= rdata_next;
		end
	end

	assign avs_waitrequest_o = wait_reg;
	assign avs_readdata_o    = rdata_reg;
	assign waveform_output_o = wave_reg;

	// ***************************************************************
	// assertions
	// ***************************************************************
	a_cap_ovf_err: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(std_ev[2] && cbv_reg[2]) |=> err_reg)
		else $error("capture overflow did not set error");
	a_fifo_move: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(cbv_reg[2] && !full_reg[2])
		|=> (full_reg[2] && cv_reg[2] == $past(cb_reg[2])))
		else $error("buffer did not move into channel value");
	a_valid_flag: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		$rose(full_reg[2]) |-> mf_reg[2])
		else $error("valid channel value without match flag");
	a_ppw_drop: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(ppw_hit[0] && mf_reg[0] && !wr_fire)
		|=> (cv_reg[0] == $past(cv_reg[0]) && err_reg))
		else $error("capture stored while match flag set");
	a_oneshot_halt: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(ovf && srun_reg) |=> (st_reg == CS_HALTED && count_reg == $past(count_reg)))
		else $error("single run did not stop at wrap");
	a_resume_run: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(ctrl_reg.enable && st_reg == CS_HALTED && ev_start_i)
		|=> (st_reg == CS_RUN && count_reg == '0))
		else $error("start event did not resume counter");
	a_ramp_mask: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(ramp_on && !idx_reg && st_reg == CS_RUN) |=> !wave_reg[1])
		else $error("odd output active in cycle a");
	a_fault_clamp: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(ctrl_reg.fault_en[0] && fault_a_i && st_reg == CS_RUN) |=> !wave_reg[0])
		else $error("fault a did not clamp output 0");
	a_circ_swap: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(upd && circ_ok && ctrl_reg.circ_per_en && !wr_fire)
		|=> (per_reg == $past(perb_reg) && perb_reg == $past(per_reg)))
		else $error("period not swapped at update");
endmodule // ptx_timer

/* File: bench/ptx_event_model.sv */
// ptx_event_model: event channels and fault inputs that feed the timer.
// assumes its tasks are called just after a rising edge of clk_i.
`timescale 1ns/1ps
module ptx_event_model (
	input  wire logic       clk_i,
	output logic      [3:0] ev_capture_o,
	output logic            ev_in1_o,
	output logic            ev_retrigger_o,
	output logic            ev_start_o,
	output logic            fault_a_o,
	output logic            fault_b_o
);
	// ***************************************************************
	// event sources
	// ***************************************************************
	// all lines idle low from time zero
	initial begin
		ev_capture_o = '0;
		ev_in1_o = 1'b0;
		ev_retrigger_o = 1'b0;
		ev_start_o = 1'b0;
		fault_a_o = 1'b0;
		fault_b_o = 1'b0;
	end
	// one-clock pulses, then a gap so the next call is a fresh event
	task automatic pulse(input logic [3:0] m, input logic rt, input logic st);
		ev_capture_o <= m;
		ev_retrigger_o <= rt;
		ev_start_o <= st;
		@(posedge clk_i);
		ev_capture_o <= '0;
		ev_retrigger_o <= 1'b0;
		ev_start_o <= 1'b0;
		@(posedge clk_i);
	endtask
	// level of the two-edge capture input
	task automatic level(input logic v);
		ev_in1_o <= v;
		@(posedge clk_i);
	endtask
	// faults steer the first two channel outputs, taken unsynchronised
	task automatic faults(input logic a, input logic b);
		fault_a_o <= a;
		fault_b_o <= b;
		@(posedge clk_i);
	endtask
endmodule // ptx_event_model

/* File: bench/testbench.sv */
// testbench: drives the timer registers over avalon-mm and its events.
// assumes ptx_pkg and ptx_event_model are compiled first.
`timescale 1ns/1ps
module testbench;
	import ptx_pkg::*;
	logic        clk_i;
	logic        rst_n_i;
	logic [5:0]  bus_addr;
	logic        bus_rd;
	logic        bus_wr;
	logic [31:0] bus_wdata;
	logic [31:0] bus_rdata;
	logic        bus_wait;
	logic [3:0]  ev_cap;
	logic        ev_in1;
	logic        ev_rt;
	logic        ev_st;
	logic        flt_a;
	logic        flt_b;
	logic [3:0]  wave;
	logic [31:0] a;
	logic [31:0] b;
	logic [31:0] q;
	int          bad_count;
	int          n_tests;
	int          cyc;
	// ***************************************************************
	// design and event source
	// ***************************************************************
	ptx_timer uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(bus_addr),
		.avs_read_i(bus_rd), .avs_write_i(bus_wr), .avs_byteenable_i(4'hf),
		.avs_writedata_i(bus_wdata), .avs_readdata_o(bus_rdata),
		.avs_waitrequest_o(bus_wait), .ev_capture_i(ev_cap), .ev_in1_i(ev_in1),
		.ev_retrigger_i(ev_rt), .ev_start_i(ev_st), .fault_a_i(flt_a),
		.fault_b_i(flt_b), .waveform_output_o(wave));
	ptx_event_model src (.clk_i(clk_i), .ev_capture_o(ev_cap), .ev_in1_o(ev_in1),
		.ev_retrigger_o(ev_rt), .ev_start_o(ev_st), .fault_a_o(flt_a),
		.fault_b_o(flt_b));
	// 100 mhz clock
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	// hang guard, well above the fewer than a thousand cycles the run needs
	always @(posedge clk_i) begin
		cyc++;
		if (cyc > 20000) begin
			bad_count++;
			print_verdict();
		end
	end
	// ***************************************************************
	// tasks
	// ***************************************************************
	task automatic check(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			bad_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	// one access, held until waitrequest is seen low; then one idle edge
	task automatic bus(input logic w, input logic [5:0] ad, input logic [31:0] d,
		output logic [31:0] r);
		bus_addr <= ad;
		bus_wr <= w;
		bus_rd <= !w;
		bus_wdata <= d;
		// no cycle count assumed; only the hang guard ends a stuck wait
		do begin
			@(posedge clk_i);
		end while (bus_wait !== 1'b0);
		r = bus_rdata;
		bus_rd <= 1'b0;
		bus_wr <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic wr(input logic [5:0] ad, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, ad, d, r);
	endtask
	// masked read compared against an expected value
	task automatic rd_chk(input logic [5:0] ad, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] r;
		bus(1'b0, ad, 32'h0, r);
		check(r & m, e);
	endtask
	// poll the stopped flag; a stuck counter shows up in the checks after
	task automatic wait_stop();
		int k;
		k = 0;
		do begin
			bus(1'b0, OFF_STAT, 32'h0, q);
			k++;
		end while (q[ST_STOP] !== 1'b1 && k < 60);
	endtask
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// ***************************************************************
	// tests
	// ***************************************************************
	initial begin
		rst_n_i = 1'b0;
		bus_addr = '0;
		bus_rd = 1'b0;
		bus_wr = 1'b0;
		bus_wdata = '0;
		bad_count = 0;
		n_tests = 0;
		cyc = 0;
		repeat (8) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(posedge clk_i);
		rd_chk(OFF_PER, 32'hffffffff, 32'h00ffffff);
		// ch2 fully enabled, ch3 event input only; spacing of 5 cycles
		wr(OFF_EVC, 32'h260);
		wr(OFF_CTRL, 32'h1);
		src.pulse(4'h4, 1'b0, 1'b0);
		repeat (3) @(posedge clk_i);
		src.pulse(4'h4, 1'b0, 1'b0);
		src.pulse(4'hc, 1'b0, 1'b0);
		rd_chk(OFF_STAT, 32'h4f8, 32'h448);
		rd_chk(6'h38, 32'hffffffff, 32'h0);
		bus(1'b0, 6'h28, 32'h0, a);
		bus(1'b0, 6'h28, 32'h0, b);
		check(b - a, 32'h5);
		rd_chk(OFF_STAT, 32'h400, 32'h0);
		$display("test capture fifo done");
		// both two-edge actions; low time of 6 cycles sets period minus pulse
		for (int i = 0; i < 2; i++) begin
			wr(OFF_EVC, 32'h198 | (i + 2));
			src.level(1'b1);
			wr(OFF_STAT, 32'hf8);
			repeat (4) @(posedge clk_i);
			src.level(1'b0);
			repeat (5) @(posedge clk_i);
			src.level(1'b1);
			src.level(1'b0);
			repeat (2) @(posedge clk_i);
			rd_chk(OFF_STAT, 32'h8, 32'h8);
			bus(1'b0, (i == 1) ? 6'h24 : 6'h20, 32'h0, a);
			bus(1'b0, (i == 1) ? 6'h20 : 6'h24, 32'h0, b);
			check(a - b, 32'h6);
		end
		$display("test two edge capture done");
		// every ramp index command in turn
		wr(OFF_CTRL, 32'h20);
		wr(OFF_CMD, 32'h10);
		rd_chk(OFF_STAT, 32'h4, 32'h4);
		wr(OFF_CMD, 32'h08);
		rd_chk(OFF_STAT, 32'h4, 32'h0);
		wr(OFF_CMD, 32'h18);
		rd_chk(OFF_STAT, 32'h4, 32'h4);
		$display("test ramp index done");
		// compare above top keeps output 0 high until fault a clamps it
		wr(OFF_EVC, 32'h0);
		wr(OFF_PER, 32'h40);
		wr(6'h20, 32'h7f);
		wr(OFF_CTRL, 32'h201);
		repeat (3) @(posedge clk_i);
		check({31'h0, wave[0]}, 32'h1);
		src.faults(1'b1, 1'b0);
		repeat (2) @(posedge clk_i);
		check({31'h0, wave[0]}, 32'h0);
		src.faults(1'b0, 1'b0);
		$display("test fault clamp done");
		// single run, resumed by command, retrigger event and start event
		wr(OFF_DRV, 32'h5f);
		wr(OFF_CTRL, 32'h1);
		wr(OFF_CMD, 32'h1);
		for (int k = 0; k < 3; k++) begin
			wait_stop();
			check({28'h0, wave}, 32'h5);
			rd_chk(OFF_STAT, 32'h3, 32'h3);
			if (k == 0)
				wr(OFF_CMD, 32'h4);
			else
				src.pulse(4'h0, k == 1, k == 2);
			rd_chk(OFF_STAT, 32'h1, 32'h0);
		end
		wr(OFF_CMD, 32'h2);
		rd_chk(OFF_STAT, 32'h2, 32'h0);
		$display("test single run done");
		// interleaved ramp with circular period: one update swaps and toggles
		wr(OFF_CMD, 32'h1);
		wait_stop();
		wr(OFF_DRV, 32'haf);
		wr(OFF_PERB, 32'h30);
		wr(OFF_CTRL, 32'h121);
		wr(OFF_CMD, 32'h4);
		wait_stop();
		rd_chk(OFF_PER, 32'hffffffff, 32'h30);
		rd_chk(OFF_PERB, 32'hffffffff, 32'h40);
		rd_chk(OFF_STAT, 32'h4, 32'h0);
		// cycle a at count 0: odd outputs masked, even ones follow compare
		wr(OFF_CMD, 32'h4);
		@(posedge clk_i);
		check({28'h0, wave}, 32'h5);
		wait_stop();
		$display("test circular ramp done");
		// dual slope stops at the bottom while falling; capture marks msb
		wr(OFF_CTRL, 32'h3);
		wr(OFF_EVC, 32'h260);
		wr(OFF_CMD, 32'h4);
		wait_stop();
		src.pulse(4'h4, 1'b0, 1'b0);
		rd_chk(6'h28, 32'hffffffff, 32'h800000);
		$display("test dual slope capture done");
		print_verdict();
	end
endmodule // testbench
